// >>> dbs_pkg.sv
/*
  Shared constants, types and helpers for the burst-of-two double-data-rate
  SRAM port: data and lane layout, array depth, state codes and lane merge.
  Assumes the including design runs its link logic on the input clock pair,
  with the complementary clock rise taken as the falling edge of k_clk.

  // Function
  // RULE_01 - write command, words at t+1 edges
  // RULE_02 - read command, words out in t+1
  // RULE_03 - load strobe high: no operation, outputs off
  // RULE_04 - stopped clock holds everything unchanged
  // RULE_05 - second burst address flips address bit 0
  // RULE_06 - power-up deselected, outputs high impedance
  // RULE_07 - write words captured on both clock rises
  // RULE_08 - read words launched on output clock rises
  // RULE_09 - controller parks stopped clocks at rest levels
  // RULE_10 - narrow: selects 0,1 pick two lanes
  // RULE_11 - narrow: both selects high writes nothing
  // RULE_12 - wide: all selects low writes all
  // RULE_13 - wide: selects 0,1 own lower lanes
  // RULE_14 - wide: selects 2,3 own upper lanes
  // RULE_15 - wide: all selects high writes nothing
  // RULE_16 - selects sampled separately on each data edge
  // RULE_17 - controller inserts idle between read, write
  // RULE_18 - last write posted until next write
  // RULE_19 - read hitting posted write returns newest data
  // RULE_20 - output clocks high at power-on: single-clock mode
  // RULE_21 - one command accepted every input clock cycle
*/
package dbs_pkg;

  localparam int DBS_DATA_W = 36;
  localparam int DBS_LANE_W = 9;
  localparam int DBS_LANES = 4;
  // array depth kept small; all eight address bits index it
  localparam int DBS_ADDR_W = 8;
  localparam int DBS_DEPTH = 256;

  localparam logic [3:0] DBS_MASK_NONE = 4'hf;
  // narrow organisation never writes the two upper lanes
  localparam logic [3:0] DBS_NARROW_MASK = 4'hc;
  localparam logic [35:0] DBS_DATA_RST = 36'h0;
  localparam logic [7:0] DBS_ADDR_RST = 8'h0;
  // sys_clk cycles after reset release before the straps are trusted
  localparam logic [1:0] DBS_STRAP_SETTLE = 2'h3;

  typedef enum logic [2:0]
  {
    DBS_ST_IDLE = 3'h1,
    DBS_ST_WR = 3'h2,
    DBS_ST_RD = 3'h4
  } dbs_state_t;

  // one data word with its active-low lane selects
  typedef struct packed
  {
    logic [35:0] data;
    logic [3:0] mask_n;
  } dbs_word_t;

  localparam dbs_word_t DBS_WORD_RST = '{data: 36'h0, mask_n: 4'hf};

  // lanes with a low select take the new data, others keep the old
  function automatic logic [35:0] dbs_merge(
    input logic [35:0] old_data,
    input logic [35:0] new_data,
    input logic [3:0] mask_n
  );
    logic [35:0] res;
    res = old_data;
    for (int i = 0; i < DBS_LANES; i++)
    begin
      if (!mask_n[i])
      begin
        res[i*DBS_LANE_W +: DBS_LANE_W] = new_data[i*DBS_LANE_W +: DBS_LANE_W];
      end
    end
    return res;
  endfunction

endpackage

// >>> dbs_sync.sv
/*
  Three-stage level synchroniser with agreement filter.
  Assumes d is a level from another clock domain or a pin; q moves only
  when the second and third stages agree.
*/
`timescale 1ns/10ps
module dbs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // first stage feeds only the second; no reset so metastability can settle
  always_ff @(posedge clk)
  begin
    s1_reg <= d;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end

  // accept a change only once two settled stages agree
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      q <= RST_VAL;
    end
    else if (s2_reg == s3_reg)
    begin
      q <= s3_reg;
    end
  end

endmodule

// >>> dbs_sram_port.sv
/*
  Burst-of-two DDR SRAM port: command decode, posted write with read bypass,
  byte-lane writes for both organisations, DDR read launch and strap capture.
  Assumes the controller drives k_clk and all command and data inputs
  synchronous to it; the complementary input clock rise is the falling edge
  of k_clk. Straps and rst_b come from the sys_clk side.
*/
`timescale 1ns/10ps
module dbs_sram_port
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic k_clk,
  input wire logic load_strobe_n,
  input wire logic rw_sel,
  input wire logic [7:0] addr,
  input wire logic [35:0] wdata,
  input wire logic [3:0] byte_write_select_n,
  input wire logic out_clk_tied_high,
  input wire logic wide_org_strap,
  output logic [35:0] q_data,
  output logic q_oe_n,
  output logic single_clock_mode
);

  // sys_clk side: strap capture
  logic [1:0] strap_sync;
  logic [1:0] settle_reg;
  logic straps_done_reg;
  logic wide_org_reg;

  // k_clk side
  logic k_rst_b;
  logic k_wide_org;
  dbs_pkg::dbs_state_t state_reg;
  dbs_pkg::dbs_state_t state_next;
  dbs_pkg::dbs_state_t slot_reg;
  logic [7:0] addr_reg;
  logic [7:0] slot_addr_reg;
  logic [3:0] eff_mask_n;
  logic pend_valid_reg;
  logic [7:0] pend_addr_reg;
  dbs_pkg::dbs_word_t pend_w0_reg;
  dbs_pkg::dbs_word_t pend_w1_reg;
  logic [35:0] mem_reg [0:dbs_pkg::DBS_DEPTH-1];
  logic [35:0] q_rise_reg;
  logic [35:0] q_fall_reg;
  logic q_oe_n_reg;

  // strap levels arrive from pins, so they pass the filter first
  dbs_sync #(
    .W(2),
    .RST_VAL(2'h0)
  ) u_strap_sync (
    .clk(sys_clk),
    .rst_b(rst_b),
    .d({wide_org_strap, out_clk_tied_high}),
    .q(strap_sync)
  );

  // straps latched once after reset; later pin changes are ignored
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      settle_reg <= 2'h0;
      straps_done_reg <= 1'b0;
      single_clock_mode <= 1'b0;
      wide_org_reg <= 1'b0;
    end
    else if (settle_reg != dbs_pkg::DBS_STRAP_SETTLE)
    begin
      settle_reg <= settle_reg + 2'h1;
    end
    else if (!straps_done_reg)
    begin
      straps_done_reg <= 1'b1;
      single_clock_mode <= strap_sync[0]; // [RULE_20]
      wide_org_reg <= strap_sync[1];
    end
  end

  // reset crosses into the link domain as a filtered level
  dbs_sync #(
    .W(1),
    .RST_VAL(1'h0)
  ) u_krst_sync (
    .clk(k_clk),
    .rst_b(1'b1),
    .d(rst_b),
    .q(k_rst_b)
  );

  // organisation strap is static after capture, a level crossing suffices
  dbs_sync #(
    .W(1),
    .RST_VAL(1'h0)
  ) u_org_sync (
    .clk(k_clk),
    .rst_b(k_rst_b),
    .d(wide_org_reg),
    .q(k_wide_org)
  );

  // command decode; read/write select is ignored while the strobe is high
  always_comb
  begin
    state_next = dbs_pkg::DBS_ST_IDLE; // [RULE_03]
    if (!load_strobe_n)
    begin
      state_next = rw_sel ? dbs_pkg::DBS_ST_RD : dbs_pkg::DBS_ST_WR; // [RULE_01] [RULE_02]
    end
  end

  // lane selects seen this edge; the narrow part has no upper lanes
  always_comb
  begin
    eff_mask_n = byte_write_select_n; // [RULE_12] [RULE_13] [RULE_14] [RULE_15]
    if (!k_wide_org)
    begin
      eff_mask_n = byte_write_select_n | dbs_pkg::DBS_NARROW_MASK; // [RULE_10] [RULE_11]
    end
  end

  // command register: a new command may land on every rising edge
  always_ff @(posedge k_clk)
  begin
    if (!k_rst_b)
    begin
      state_reg <= dbs_pkg::DBS_ST_IDLE; // [RULE_06]
      slot_reg <= dbs_pkg::DBS_ST_IDLE;
      addr_reg <= dbs_pkg::DBS_ADDR_RST;
      slot_addr_reg <= dbs_pkg::DBS_ADDR_RST;
    end
    else
    begin
      state_reg <= state_next; // [RULE_21]
      slot_reg <= state_reg;
      slot_addr_reg <= addr_reg;
      if (!load_strobe_n)
      begin
        addr_reg <= addr;
      end
    end
  end

  // newest value of a word: array, overlaid by the posted write
  function automatic logic [35:0] lookup(input logic [7:0] a);
    logic [35:0] v;
    v = mem_reg[a];
    if (pend_valid_reg && a == pend_addr_reg)
    begin
      v = dbs_pkg::dbs_merge(v, pend_w0_reg.data, pend_w0_reg.mask_n); // [RULE_19]
    end
    if (pend_valid_reg && a == {pend_addr_reg[7:1], ~pend_addr_reg[0]})
    begin
      v = dbs_pkg::dbs_merge(v, pend_w1_reg.data, pend_w1_reg.mask_n); // [RULE_19]
    end
    return v;
  endfunction

  // array commit of the older posted write at the next write's first edge;
  // waiting that long keeps back-to-back writes from committing half a burst
  always_ff @(posedge k_clk)
  begin
    if (k_rst_b && state_reg == dbs_pkg::DBS_ST_WR && pend_valid_reg)
    begin
      mem_reg[pend_addr_reg] <= dbs_pkg::dbs_merge(mem_reg[pend_addr_reg],
        pend_w0_reg.data, pend_w0_reg.mask_n); // [RULE_18]
      mem_reg[{pend_addr_reg[7:1], ~pend_addr_reg[0]}] <= dbs_pkg::dbs_merge(
        mem_reg[{pend_addr_reg[7:1], ~pend_addr_reg[0]}],
        pend_w1_reg.data, pend_w1_reg.mask_n); // [RULE_05] [RULE_18]
    end
  end

  // first write word and its selects, taken at the rising edge of t+1
  always_ff @(posedge k_clk)
  begin
    if (!k_rst_b)
    begin
      pend_valid_reg <= 1'b0;
      pend_addr_reg <= dbs_pkg::DBS_ADDR_RST;
      pend_w0_reg <= dbs_pkg::DBS_WORD_RST;
    end
    else if (state_reg == dbs_pkg::DBS_ST_WR)
    begin
      pend_valid_reg <= 1'b1;
      pend_addr_reg <= addr_reg;
      pend_w0_reg <= '{data: wdata, mask_n: eff_mask_n}; // [RULE_01] [RULE_07] [RULE_16]
    end
  end

  // second write word on the complementary rise; selects sampled afresh
  always_ff @(negedge k_clk)
  begin
    if (!k_rst_b)
    begin
      pend_w1_reg <= dbs_pkg::DBS_WORD_RST;
    end
    else if (slot_reg == dbs_pkg::DBS_ST_WR)
    begin
      pend_w1_reg <= '{data: wdata, mask_n: eff_mask_n}; // [RULE_07] [RULE_16]
    end
  end

  // first read word and the output enable for the coming data slot
  always_ff @(posedge k_clk)
  begin
    if (!k_rst_b)
    begin
      q_rise_reg <= dbs_pkg::DBS_DATA_RST;
      q_oe_n_reg <= 1'b1; // [RULE_06]
    end
    else
    begin
      case (state_reg)
        dbs_pkg::DBS_ST_RD:
        begin
          q_rise_reg <= lookup(addr_reg); // [RULE_02] [RULE_08]
          q_oe_n_reg <= 1'b0;
        end
        dbs_pkg::DBS_ST_WR:
        begin
          q_oe_n_reg <= 1'b1;
        end
        default:
        begin
          q_oe_n_reg <= 1'b1; // [RULE_03]
        end
      endcase
    end
  end

  // second read word: first address with bit 0 flipped
  always_ff @(negedge k_clk)
  begin
    if (!k_rst_b)
    begin
      q_fall_reg <= dbs_pkg::DBS_DATA_RST;
    end
    else if (slot_reg == dbs_pkg::DBS_ST_RD)
    begin
      q_fall_reg <= lookup({slot_addr_reg[7:1], ~slot_addr_reg[0]}); // [RULE_05] [RULE_08]
    end
  end

  // ddr output: high phase shows the rise word, low phase the fall word;
  // with k_clk stopped every k_clk register holds, so the pins keep their state
  assign q_data = k_clk ? q_rise_reg : q_fall_reg; // [RULE_04] [RULE_08]
  assign q_oe_n = q_oe_n_reg;

  property p_wr_decode;
    @(posedge k_clk) disable iff (!k_rst_b)
    (!load_strobe_n && !rw_sel) |=> state_reg == dbs_pkg::DBS_ST_WR;
  endproperty
  a_wr_decode: assert property (p_wr_decode) // [RULE_01]
    else $error("write command not decoded");

  property p_rd_drive;
    @(posedge k_clk) disable iff (!k_rst_b)
    (!load_strobe_n && rw_sel) |=> ##1 !q_oe_n_reg;
  endproperty
  a_rd_drive: assert property (p_rd_drive) // [RULE_02]
    else $error("read data not driven in the slot after the command");

  property p_nop_hiz;
    @(posedge k_clk) disable iff (!k_rst_b)
    load_strobe_n |=> ##1 q_oe_n_reg;
  endproperty
  a_nop_hiz: assert property (p_nop_hiz) // [RULE_03]
    else $error("outputs driven in a no-operation slot");

  property p_power_desel;
    @(posedge k_clk)
    $rose(k_rst_b) |-> q_oe_n_reg && state_reg == dbs_pkg::DBS_ST_IDLE;
  endproperty
  a_power_desel: assert property (p_power_desel) // [RULE_06]
    else $error("device not deselected after reset");

  property p_word0_capture;
    @(posedge k_clk) disable iff (!k_rst_b)
    state_reg == dbs_pkg::DBS_ST_WR |=> pend_valid_reg
      && pend_w0_reg.data == $past(wdata) && pend_addr_reg == $past(addr_reg);
  endproperty
  a_word0_capture: assert property (p_word0_capture) // [RULE_07]
    else $error("first write word or address not posted");

  property p_word1_capture;
    @(negedge k_clk) disable iff (!k_rst_b)
    slot_reg == dbs_pkg::DBS_ST_WR |=> pend_w1_reg.data == $past(wdata)
      && pend_w1_reg.mask_n == $past(eff_mask_n);
  endproperty
  a_word1_capture: assert property (p_word1_capture) // [RULE_16]
    else $error("second write word or selects not captured");

  property p_no_lanes;
    @(posedge k_clk) disable iff (!k_rst_b)
    (state_reg == dbs_pkg::DBS_ST_WR && byte_write_select_n == 4'hf)
      |=> pend_w0_reg.mask_n == dbs_pkg::DBS_MASK_NONE;
  endproperty
  a_no_lanes: assert property (p_no_lanes) // [RULE_15]
    else $error("lanes enabled with all selects high");

  property p_narrow_upper;
    @(posedge k_clk) disable iff (!k_rst_b)
    (state_reg == dbs_pkg::DBS_ST_WR && !k_wide_org)
      |=> pend_w0_reg.mask_n[3:2] == 2'h3;
  endproperty
  a_narrow_upper: assert property (p_narrow_upper) // [RULE_10]
    else $error("upper lanes enabled in narrow organisation");

  property p_bypass;
    @(posedge k_clk) disable iff (!k_rst_b)
    (state_reg == dbs_pkg::DBS_ST_RD && pend_valid_reg && addr_reg == pend_addr_reg
      && pend_w0_reg.mask_n == 4'h0) |=> q_rise_reg == $past(pend_w0_reg.data);
  endproperty
  a_bypass: assert property (p_bypass) // [RULE_19]
    else $error("read missed the posted write data");

  // second word of a narrow burst must never open the upper lanes either
  property p_narrow_upper_w1;
    @(negedge k_clk) disable iff (!k_rst_b)
    (slot_reg == dbs_pkg::DBS_ST_WR && !k_wide_org)
      |=> pend_w1_reg.mask_n[3:2] == 2'h3;
  endproperty
  a_narrow_upper_w1: assert property (p_narrow_upper_w1) // [RULE_10]
    else $error("upper lanes enabled on second narrow word");

endmodule

// >>> dbs_ctrl_model.sv
/*
  Controller model for the burst-of-two SRAM port: makes k_clk, commands
  and write words, and samples read words in each clock phase.
  Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/10ps
module dbs_ctrl_model
(
  output logic k_clk,
  output logic load_strobe_n,
  output logic rw_sel,
  output logic [7:0] addr,
  output logic [35:0] wdata,
  output logic [3:0] byte_write_select_n,
  input wire logic [35:0] q_data,
  input wire logic q_oe_n
);
  logic [35:0] qh;
  logic [35:0] ql;
  logic oeh;

  // clock parked low between frames, strobe idle high
  initial
  begin
    k_clk = 1'b0;
    load_strobe_n = 1'b1;
    rw_sel = 1'b0;
    addr = 8'h0;
    wdata = 36'h0;
    byte_write_select_n = 4'hf;
  end

  // one cycle; cmd 0 idle, 1 write, 2 read; unused pins toggle so stale data never helps
  task automatic kcyc(input logic [1:0] cmd, input logic [7:0] a, input logic [35:0] d0,
    input logic [3:0] m0, input logic [35:0] d1, input logic [3:0] m1);
    load_strobe_n <= (cmd == 2'h0);
    rw_sel <= (cmd == 2'h2);
    addr <= (cmd == 2'h0) ? ~addr : a;
    wdata <= (m0 == 4'hf) ? ~wdata : d0;
    byte_write_select_n <= m0;
    #1.5 k_clk = 1'b1;
    #1.5 qh = q_data;
    oeh = q_oe_n;
    wdata <= (m1 == 4'hf) ? ~wdata : d1;
    byte_write_select_n <= m1;
    #1.5 k_clk = 1'b0;
    #1.5 ql = q_data;
  endtask

  // clock stopped with a live-looking read on the pins
  task automatic stall(input int ns);
    load_strobe_n <= 1'b0;
    rw_sel <= 1'b1;
    addr <= ~addr;
    #(ns);
  endtask
endmodule

// >>> tb_top.sv
/*
  Self-checking bench for the burst-of-two SRAM port.
  Assumes the controller model supplies k_clk and all link stimulus.
*/
`timescale 1ns/10ps
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic out_clk_tied_high = 1'b0;
  logic wide_org_strap = 1'b1;
  logic k_clk;
  logic load_strobe_n;
  logic rw_sel;
  logic [7:0] addr;
  logic [35:0] wdata;
  logic [3:0] byte_write_select_n;
  logic [35:0] q_data;
  logic q_oe_n;
  logic single_clock_mode;
  logic [35:0] exp_mem [256];
  logic narrow = 1'b0;
  int fails = 0;
  int tests_run = 0;

  always #50 sys_clk = ~sys_clk;

  dbs_sram_port uut (.sys_clk(sys_clk), .rst_b(rst_b), .k_clk(k_clk),
    .load_strobe_n(load_strobe_n), .rw_sel(rw_sel), .addr(addr), .wdata(wdata),
    .byte_write_select_n(byte_write_select_n), .out_clk_tied_high(out_clk_tied_high),
    .wide_org_strap(wide_org_strap), .q_data(q_data), .q_oe_n(q_oe_n),
    .single_clock_mode(single_clock_mode));

  dbs_ctrl_model ctrl (.k_clk(k_clk), .load_strobe_n(load_strobe_n), .rw_sel(rw_sel),
    .addr(addr), .wdata(wdata), .byte_write_select_n(byte_write_select_n),
    .q_data(q_data), .q_oe_n(q_oe_n));

  task automatic wrap_up;
    if (fails == 0 && tests_run > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [35:0] seen, input logic [35:0] want);
    tests_run++;
    if (seen !== want)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // lanes with a low select take new data
  function automatic logic [35:0] mix(input logic [35:0] o, input logic [35:0] n,
    input logic [3:0] m);
    for (int i = 0; i < 4; i++)
    begin
      if (!m[i])
      begin
        o[i*9 +: 9] = n[i*9 +: 9];
      end
    end
    return o;
  endfunction

  task automatic no_operation;
    ctrl.kcyc(2'h0, 8'h0, 36'h0, 4'hf, 36'h0, 4'hf);
  endtask

  // k_clk keeps running through reset so the filtered reset reaches the link side
  task automatic do_reset(input logic wide, input logic tied);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    wide_org_strap <= wide;
    out_clk_tied_high <= tied;
    narrow = !wide;
    repeat (20)
    begin
      @(posedge sys_clk);
      no_operation;
    end
    repeat (10)
    begin
      @(posedge sys_clk);
      rst_b <= 1'b1;
      no_operation;
    end
  endtask

  // narrow organisation only owns the two lower lanes
  task automatic answer(input logic [7:0] a);
    logic [35:0] k;
    k = narrow ? 36'h00003ffff : 36'hfffffffff;
    no_operation;
    check({35'h0, ctrl.oeh}, 36'h0);
    check(ctrl.qh & k, exp_mem[a] & k);
    check(ctrl.ql & k, exp_mem[a ^ 8'h1] & k);
  endtask

  task automatic wr(input logic [7:0] a, input logic [35:0] d0, input logic [3:0] m0,
    input logic [35:0] d1, input logic [3:0] m1, input logic rd_next);
    ctrl.kcyc(2'h1, a, 36'h0, 4'hf, 36'h0, 4'hf);
    ctrl.kcyc(rd_next ? 2'h2 : 2'h0, a, d0, m0, d1, m1);
    exp_mem[a] = mix(exp_mem[a], d0, m0 | {narrow, narrow, 2'h0});
    exp_mem[a ^ 8'h1] = mix(exp_mem[a ^ 8'h1], d1, m1 | {narrow, narrow, 2'h0});
    if (rd_next)
    begin
      answer(a);
    end
  endtask

  // answer cycle doubles as the idle slot before any following write
  task automatic rd(input logic [7:0] a);
    ctrl.kcyc(2'h2, a, 36'h0, 4'hf, 36'h0, 4'hf);
    answer(a);
  endtask

  initial
  begin
    do_reset(1'b1, 1'b0);
    check({35'h0, q_oe_n}, 36'h1);
    check({35'h0, single_clock_mode}, 36'h0);
    // full words, read straight after the write, then 8'h10 from the array and 8'h21 from the posted write
    wr(8'h10, 36'h123456789, 4'h0, 36'hfedcba987, 4'h0, 1'b1);
    wr(8'h21, 36'h0a5a5a5a5, 4'h0, 36'h5a5a5a5a5, 4'h0, 1'b0);
    rd(8'h10);
    rd(8'h21);
    // lane selects change between the two words of one burst
    wr(8'h21, 36'hfffffffff, 4'ha, 36'h111111111, 4'hf, 1'b1);
    wr(8'h10, 36'h222222222, 4'h5, 36'h333333333, 4'h6, 1'b0);
    rd(8'h10);
    // stopped clock: outputs hold the last read word and ignore the read on the pins
    ctrl.stall(500);
    check(q_data, exp_mem[8'h11]);
    check({35'h0, q_oe_n}, 36'h0);
    no_operation;
    check({35'h0, ctrl.oeh}, 36'h1);
    rd(8'h21);
    // first word with every select high, second word full
    wr(8'h21, 36'h888888888, 4'hf, 36'h999999999, 4'h0, 1'b1);
    // flush the posted pair so reset cannot lose it
    wr(8'h40, 36'h0, 4'h0, 36'h0, 4'h0, 1'b0);
    do_reset(1'b0, 1'b1);
    check({35'h0, single_clock_mode}, 36'h1);
    wr(8'h10, 36'h444444444, 4'h0, 36'h555555555, 4'h3, 1'b1);
    wr(8'h21, 36'h666666666, 4'he, 36'h777777777, 4'hd, 1'b0);
    rd(8'h21);
    wrap_up;
  end

  // whole run needs well under 20 us; allow ten times that
  initial
  begin
    #200000;
    fails++;
    wrap_up;
  end
endmodule
